//--- src/tcc_pkg.sv
// tape cache command control: shared constants and types
// assumes a single 10 MHz clock domain and an AXI4-Lite master
package tcc_pkg;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_STAT   = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_SENSE  = 8'h0C;
    localparam logic [7:0] ADDR_CFG    = 8'h10;

    // ---------------------------------------------------------------
    // command opcodes
    // ---------------------------------------------------------------
    localparam logic [3:0] OP_NOP      = 4'h0;
    localparam logic [3:0] OP_READ_FWD = 4'h1;
    localparam logic [3:0] OP_READ_BWD = 4'h2;
    localparam logic [3:0] OP_WRITE    = 4'h3;
    localparam logic [3:0] OP_WTM      = 4'h4;
    localparam logic [3:0] OP_DRAIN    = 4'h5;
    localparam logic [3:0] OP_SENSE    = 4'h6;
    localparam logic [3:0] OP_CSENSE   = 4'h7;
    localparam logic [3:0] OP_RESET    = 4'h8;
    localparam logic [3:0] OP_MODE_SET = 4'h9;
    localparam logic [3:0] OP_WRITE_EXT = 4'hA;
    localparam logic [3:0] OP_SPACE    = 4'hB;

    // ---------------------------------------------------------------
    // limits, field positions and answers
    // ---------------------------------------------------------------
    localparam logic [7:0] SENSE_MIN   = 8'h3B;   // 59 bytes
    localparam logic [8:0] MAX_RECS    = 9'h0FF;  // 255 records
    localparam logic [8:0] LONG_RECS   = 9'h001;
    localparam int         MS_LONG_BIT = 0;
    localparam int         MS_DATA_BIT = 1;
    localparam int         CFG_VAR_BIT = 0;
    localparam int         CFG_TM2_BIT = 1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] arg;
        logic [3:0] op;
    } tcc_cmd_t;

    typedef struct packed {
        logic corrected;
        logic bad;
    } tcc_rec_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FLUSH = 3'b010,
        ST_ALIGN = 3'b100
    } tcc_state_t;

endpackage : tcc_pkg

//--- src/tcc_top.sv
// tape cache command control: command interpreter behind AXI4-Lite
// assumes tape engine strobes are synchronous to aclk, one per record
//
// Notes on behaviour
// - corrected read-ahead record flags correction on delivery; errors summed
// - unreadable read-ahead record still delivered, with data fault status
// - configured run of tape-mark writes (one or two) drains the cache
// - non-read command discards read-ahead and realigns; first variant no-op exempt
// - only forward read and write keep records; others align tape (here a first-variant no-op also keeps read-ahead)
// - long-record mode holds at most one record in cache
// - failed buffered write rejects next and later commands, sense excepted
// - sense reports count of records left unwritten in cache
// - mode set or extended write enters cache data mode, no tape
// - reject persists while no sense command has been issued
// - first variant sense must ask at least 59 bytes to count
// - sufficient sense followed by reset leaves the reject state
// - mode set chooses buffered or long-record operation
// - power-on mode follows the option switch
// - drain command writes all cached blocks before next command
// - buffered mode holds at most 255 records
//
// Our own choices: register access over AXI4-Lite and the address map.
module tcc_top #(
    parameter int REC_DEPTH = 256
) (
    input  wire logic        aclk,          // 10 MHz clock
    input  wire logic        aresetn,       // sync reset
    input  wire logic        awvalid,       // write address valid
    output logic             awready,       // write address ready
    input  wire logic [7:0]  awaddr,        // write byte address
    input  wire logic        wvalid,        // write data valid
    output logic             wready,        // write data ready
    input  wire logic [31:0] wdata,         // write data
    input  wire logic [3:0]  wstrb,         // byte enables
    output logic             bvalid,        // write response valid
    input  wire logic        bready,        // write response ready
    output logic [1:0]       bresp,         // write response
    input  wire logic        arvalid,       // read address valid
    output logic             arready,       // read address ready
    input  wire logic [7:0]  araddr,        // read byte address
    output logic             rvalid,        // read data valid
    input  wire logic        rready,        // read data ready
    output logic [31:0]      rdata,         // read data
    output logic [1:0]       rresp,         // read response
    input  wire logic        opt_long,      // power-on long-record switch
    input  wire logic        opt_tm_two,    // drain after two tape marks
    input  wire logic        opt_second,    // second interface variant
    input  wire logic        ra_valid,      // read-ahead record arrives
    output logic             ra_ready,      // cache takes read-ahead
    input  wire tcc_pkg::tcc_rec_t ra_stat, // read-ahead record status
    output logic             wr_avail,      // cached writes await tape
    input  wire logic        wr_done,       // one cached record written
    input  wire logic        wr_fail,       // write retries exhausted
    output logic             drain_req,     // write cache out to tape
    output logic             align_req,     // reposition to host position
    input  wire logic        align_done,    // repositioning finished
    output logic             tape_en        // tape motion allowed
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    tcc_pkg::tcc_state_t st;
    tcc_pkg::tcc_state_t next_st;
    tcc_pkg::tcc_rec_t   rec_mem [REC_DEPTH];
    tcc_pkg::tcc_cmd_t   cmd;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        aw_hold;
    logic        w_hold;
    logic [7:0]  ar_addr;
    logic        strap_done;
    logic        long_mode;
    logic        cache_data;
    logic        variant2;
    logic        tm_two;
    logic        read_on;
    logic        reject_st;
    logic        sense_ok;
    logic [1:0]  tm_run;
    logic [8:0]  ra_cnt;
    logic [8:0]  wr_pend;
    logic [8:0]  unwritten;
    logic [7:0]  err_sum;
    logic [7:0]  wr_ptr;
    logic [7:0]  rd_ptr;
    logic [3:0]  result;
    logic        cmd_pend;
    logic        blocked;
    logic        exec;
    logic        normal;
    logic        deliver;
    logic        discard;
    logic        wr_acc;
    logic        tm_hit;
    logic        flush;
    logic        sense_go;
    logic        clr_go;
    logic        ra_take;
    logic        wr_full;

    function automatic logic [8:0] rec_limit(input logic lng);
        rec_limit = lng ? tcc_pkg::LONG_RECS : tcc_pkg::MAX_RECS;
    endfunction : rec_limit

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    assign cmd      = tcc_pkg::tcc_cmd_t'({w_data[15:8], w_data[3:0]});
    assign cmd_pend = aw_hold && w_hold && !bvalid
                      && aw_addr == tcc_pkg::ADDR_CMD;
    assign wr_full  = wr_pend >= rec_limit(long_mode);
    assign ra_take  = ra_valid && ra_ready;

    always_comb begin
        blocked  = !cache_data && !reject_st
                   && ((cmd.op == tcc_pkg::OP_READ_FWD && ra_cnt == 9'h000)
                   || (cmd.op == tcc_pkg::OP_WRITE && wr_full));
        exec     = cmd_pend && st == tcc_pkg::ST_IDLE && !blocked;
        normal   = exec && !reject_st;
        deliver  = normal && !cache_data
                   && cmd.op == tcc_pkg::OP_READ_FWD;
        // no-op on the first variant leaves read-ahead alone
        discard  = normal && !cache_data && (ra_cnt != 9'h000 || read_on)
                   && cmd.op != tcc_pkg::OP_READ_FWD
                   && !(cmd.op == tcc_pkg::OP_NOP && !variant2);
        wr_acc   = normal && !cache_data && cmd.op == tcc_pkg::OP_WRITE;
        tm_hit   = cmd.op == tcc_pkg::OP_WTM
                   && (tm_two ? tm_run != 2'h0 : 1'b1);
        flush    = normal && !cache_data && wr_pend != 9'h000
                   && cmd.op != tcc_pkg::OP_WRITE
                   && cmd.op != tcc_pkg::OP_NOP
                   && !(cmd.op == tcc_pkg::OP_WTM && !tm_hit);
        sense_go = exec && reject_st
                   && ((cmd.op == tcc_pkg::OP_SENSE
                   && (variant2 || cmd.arg >= tcc_pkg::SENSE_MIN))
                   || (cmd.op == tcc_pkg::OP_CSENSE && variant2));
        clr_go   = exec && reject_st && sense_ok
                   && cmd.op == tcc_pkg::OP_RESET;
    end

    // ---------------------------------------------------------------
    // command sequencer
    // ---------------------------------------------------------------
    always_comb begin
        case (st)
            tcc_pkg::ST_IDLE: begin
                if (discard) begin
                    next_st = tcc_pkg::ST_ALIGN;
                end else if (flush) begin
                    next_st = tcc_pkg::ST_FLUSH;
                end else begin
                    next_st = tcc_pkg::ST_IDLE;
                end
            end
            tcc_pkg::ST_FLUSH: begin
                // a write failure strands the rest; stop draining
                if (wr_pend == 9'h000 || reject_st || wr_fail) begin
                    next_st = tcc_pkg::ST_IDLE;
                end else begin
                    next_st = tcc_pkg::ST_FLUSH;
                end
            end
            tcc_pkg::ST_ALIGN: begin
                next_st = align_done ? tcc_pkg::ST_IDLE : tcc_pkg::ST_ALIGN;
            end
            default: next_st = tcc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= tcc_pkg::ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign drain_req = st == tcc_pkg::ST_FLUSH;
    assign align_req = st == tcc_pkg::ST_ALIGN;
    assign tape_en   = !cache_data;
    assign wr_avail  = wr_pend != 9'h000 && !cache_data;
    assign ra_ready  = read_on && !cache_data && wr_pend == 9'h000
                       && ra_cnt < rec_limit(long_mode);

    // ---------------------------------------------------------------
    // modes and options
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_done <= 1'b0;
            long_mode  <= 1'b0;
            cache_data <= 1'b0;
            variant2   <= 1'b0;
            tm_two     <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            long_mode  <= opt_long;
            variant2   <= opt_second;
            tm_two     <= opt_tm_two;
        end else if (aw_hold && w_hold && !bvalid
                     && aw_addr == tcc_pkg::ADDR_CFG && wstrb[0]) begin
            variant2 <= w_data[tcc_pkg::CFG_VAR_BIT];
            tm_two   <= w_data[tcc_pkg::CFG_TM2_BIT];
        end else if (normal && !variant2
                     && cmd.op == tcc_pkg::OP_MODE_SET) begin
            long_mode  <= cmd.arg[tcc_pkg::MS_LONG_BIT];
            cache_data <= cmd.arg[tcc_pkg::MS_DATA_BIT];
        end else if (normal && variant2
                     && cmd.op == tcc_pkg::OP_WRITE_EXT) begin
            cache_data <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // read-ahead cache
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_on <= 1'b0;
            ra_cnt  <= 9'h000;
            wr_ptr  <= 8'h00;
            rd_ptr  <= 8'h00;
        end else if (discard) begin
            read_on <= 1'b0;
            ra_cnt  <= 9'h000;
            wr_ptr  <= 8'h00;
            rd_ptr  <= 8'h00;
        end else begin
            if (cmd_pend && !reject_st && !cache_data
                && st == tcc_pkg::ST_IDLE
                && cmd.op == tcc_pkg::OP_READ_FWD) begin
                read_on <= 1'b1;
            end
            if (ra_take) begin
                wr_ptr <= wr_ptr + 8'h01;
            end
            if (deliver) begin
                rd_ptr <= rd_ptr + 8'h01;
            end
            ra_cnt <= ra_cnt + {8'h00, ra_take} - {8'h00, deliver};
        end
    end

    always_ff @(posedge aclk) begin
        if (ra_take) begin
            rec_mem[wr_ptr] <= ra_stat;
        end
    end

    // ---------------------------------------------------------------
    // buffered writes and reject state
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_pend   <= 9'h000;
            unwritten <= 9'h000;
            reject_st <= 1'b0;
            sense_ok  <= 1'b0;
        end else begin
            if (wr_fail && wr_pend != 9'h000) begin
                // the fail wins over any clear in the same cycle
                wr_pend   <= 9'h000;
                unwritten <= wr_pend;
                reject_st <= 1'b1;
                sense_ok  <= 1'b0;
            end else begin
                wr_pend <= wr_pend + {8'h00, wr_acc}
                           - {8'h00, wr_done && wr_pend != 9'h000};
                if (clr_go) begin
                    reject_st <= 1'b0;
                    unwritten <= 9'h000;
                    sense_ok  <= 1'b0;
                end else if (sense_go) begin
                    sense_ok <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tm_run <= 2'h0;
        end else if (normal) begin
            tm_run <= (cmd.op == tcc_pkg::OP_WTM && !tm_hit)
                      ? tm_run + 2'h1 : 2'h0;
        end
    end

    // ---------------------------------------------------------------
    // per-command status and error summary
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result <= 4'h0;
        end else if (exec) begin
            result[0] <= reject_st && !clr_go
                         && cmd.op != tcc_pkg::OP_SENSE
                         && cmd.op != tcc_pkg::OP_CSENSE;
            result[1] <= deliver && rec_mem[rd_ptr].corrected;
            result[2] <= deliver && rec_mem[rd_ptr].bad;
            result[3] <= sense_go;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_sum <= 8'h00;
        end else if (ra_take && (ra_stat.corrected || ra_stat.bad)
                     && err_sum != 8'hFF) begin
            err_sum <= err_sum + 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite slave
    // ---------------------------------------------------------------
    assign awready = !aw_hold && !bvalid;
    assign wready  = !w_hold && !bvalid;
    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            bvalid  <= 1'b0;
            bresp   <= tcc_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_hold <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold <= 1'b1;
                w_data <= wdata;
            end
            // a command holds its response until it is executed
            if (aw_hold && w_hold && !bvalid
                && (aw_addr != tcc_pkg::ADDR_CMD || exec)) begin
                aw_hold <= 1'b0;
                w_hold  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (aw_addr == tcc_pkg::ADDR_CMD
                            || aw_addr == tcc_pkg::ADDR_CFG)
                           ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= tcc_pkg::RESP_OKAY;
            ar_addr <= 8'h00;
        end else if (arvalid && arready) begin
            rvalid  <= 1'b1;
            ar_addr <= araddr;
            rresp   <= tcc_pkg::RESP_OKAY;
            case (araddr)
                tcc_pkg::ADDR_STAT: rdata <= {6'h00, wr_pend, ra_cnt,
                    3'h0, sense_ok, st != tcc_pkg::ST_IDLE, cache_data,
                    long_mode, reject_st};
                tcc_pkg::ADDR_RESULT: rdata <= {28'h0000000, result};
                tcc_pkg::ADDR_SENSE: rdata <= {8'h00, err_sum, 7'h00,
                    unwritten};
                tcc_pkg::ADDR_CFG: rdata <= {30'h00000000, tm_two,
                    variant2};
                tcc_pkg::ADDR_CMD: rdata <= 32'h0000_0000;
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= tcc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_ra_limit: assert property (@(posedge aclk) disable iff (!aresetn)
        ra_cnt <= rec_limit(long_mode) || $past(discard) == 1'b0
            && $past(long_mode) != long_mode)
        else $error("read-ahead count above mode limit");

    chk_buf_cap: assert property (@(posedge aclk) disable iff (!aresetn)
        ra_cnt <= tcc_pkg::MAX_RECS && wr_pend <= tcc_pkg::MAX_RECS)
        else $error("cache holds more than 255 records");

    chk_discard_al: assert property (@(posedge aclk) disable iff (!aresetn)
        discard |=> align_req && ra_cnt == 9'h000)
        else $error("discard did not clear cache and align");

    chk_drain_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        drain_req && wr_pend != 9'h000 && !wr_fail |=> !exec)
        else $error("command executed during drain");

    chk_fail_rej: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fail && wr_pend != 9'h000 |=> reject_st
            && unwritten == $past(wr_pend))
        else $error("write failure did not enter reject");

    chk_rej_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        reject_st && !clr_go |=> reject_st)
        else $error("reject left without sense and reset");

    chk_rej_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && reject_st && cmd.op == tcc_pkg::OP_WRITE
            && !sense_ok |=> result[0])
        else $error("command not rejected in reject state");

    chk_short_sense: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && reject_st && !variant2 && cmd.op == tcc_pkg::OP_SENSE
            && cmd.arg < tcc_pkg::SENSE_MIN && !sense_ok
            |=> !sense_ok ##1 reject_st)
        else $error("short sense counted");

    chk_data_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        cache_data |-> !ra_ready && !wr_avail && !wr_acc)
        else $error("tape used in cache data mode");

    chk_mark_drain: assert property (@(posedge aclk) disable iff (!aresetn)
        normal && cmd.op == tcc_pkg::OP_WTM && !tm_two && !cache_data
            && wr_pend != 9'h000 |=> drain_req)
        else $error("tape mark did not drain cache");

    chk_flag_fault: assert property (@(posedge aclk) disable iff (!aresetn)
        deliver && rec_mem[rd_ptr].bad |=> result[2])
        else $error("bad record delivered without fault");

endmodule : tcc_top

//--- tb/tb_top.sv
// bench for the tape cache command interpreter
// assumes tcc_top and the tape model; AXI4-Lite master tasks
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [1:0]  r;
    } tcc_row_t;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, opt_long = 0, opt_tm_two = 0;
    logic opt_second = 0, ra_go = 0, stall = 0, fail_now = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, d, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  r, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, ra_ready, ra_valid;
    logic wr_avail, wr_done, wr_fail, drain_req, align_req, align_done;
    logic tape_en;
    tcc_pkg::tcc_rec_t ra_kind = '0, ra_stat;
    int err_count = 0, checks_done = 0;
    tcc_row_t rows [6] = '{'{8'h00, 0, 0}, '{8'h04, 0, 0}, '{8'h08, 0, 0},
        '{8'h0C, 0, 0}, '{8'h10, 0, 0}, '{8'h14, 0, 2'h2}};
    always #50 aclk = ~aclk;
    tcc_top dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .opt_long,
        .opt_tm_two, .opt_second, .ra_valid, .ra_ready, .ra_stat, .wr_avail,
        .wr_done, .wr_fail, .drain_req, .align_req, .align_done, .tape_en);
    tcc_tape_model tape (.aclk, .aresetn, .ra_go, .ra_kind, .stall,
        .fail_now, .ra_ready, .wr_avail, .align_req, .ra_valid, .ra_stat,
        .wr_done, .wr_fail, .align_done);
    // -----------
    // bus helpers
    // -----------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, v};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        {arvalid, rready, araddr} <= {2'h3, a};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 0;
    endtask : rd
    task automatic cmd(input logic [3:0] op, input logic [7:0] arg);
        wr(8'h00, {16'h0, arg, 4'h0, op});
    endtask : cmd
    task automatic offer(input tcc_pkg::tcc_rec_t k);
        @(posedge aclk);
        {ra_go, ra_kind} <= {1'b1, k};
        @(posedge aclk);
        ra_go <= 0;
        repeat (3) @(posedge aclk);
    endtask : offer
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // -----
    // tests
    // -----
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        foreach (rows[i]) begin
            rd(rows[i].a);
            chk(r, rows[i].r);
            if (r == 0) chk(d, rows[i].d);
        end
        $display("defaults done");
        // first read waits for tape; three records arrive meanwhile
        fork
            cmd(tcc_pkg::OP_READ_FWD, 0);
            begin
                offer(2'b10);
                offer(2'b01);
                offer(2'b00);
            end
        join
        rd(8'h08);
        chk(d, 2);
        cmd(tcc_pkg::OP_NOP, 0);
        rd(8'h04);
        chk(d[16:8], 2);
        cmd(tcc_pkg::OP_READ_FWD, 0);
        rd(8'h08);
        chk(d, 4);
        rd(8'h0C);
        chk(d[23:16], 2);
        cmd(tcc_pkg::OP_SPACE, 0);
        rd(8'h04);
        chk(d[16:8], 0);
        $display("read-ahead done");
        // drain, one tape mark, then two tape marks in a row
        for (int i = 0; i < 3; i++) begin
            if (i == 2) wr(8'h10, 2);
            stall <= 1;
            repeat (2) cmd(tcc_pkg::OP_WRITE, 0);
            if (i == 2) begin
                cmd(tcc_pkg::OP_WTM, 0);
                chk(drain_req, 0);
            end
            fork
                cmd(i ? tcc_pkg::OP_WTM : tcc_pkg::OP_DRAIN, 0);
                begin
                    repeat (20) @(posedge aclk);
                    chk(drain_req, 1);
                    stall <= 0;
                    wait (!drain_req);
                end
            join
            rd(8'h04);
            chk(d[25:17], 0);
        end
        $display("drain done");
        stall <= 1;
        repeat (3) cmd(tcc_pkg::OP_WRITE, 0);
        fail_now <= 1;
        @(posedge aclk);
        fail_now <= 0;
        rd(8'h0C);
        chk(d[8:0], 3);
        cmd(tcc_pkg::OP_NOP, 0);
        rd(8'h08);
        chk(d[0], 1);
        cmd(tcc_pkg::OP_SENSE, 8'h3A);
        cmd(tcc_pkg::OP_RESET, 0);
        rd(8'h04);
        chk(d[0], 1);
        cmd(tcc_pkg::OP_SENSE, 8'h3B);
        cmd(tcc_pkg::OP_RESET, 0);
        rd(8'h04);
        chk(d[0], 0);
        wr(8'h10, 1);
        cmd(tcc_pkg::OP_WRITE, 0);
        fail_now <= 1;
        @(posedge aclk);
        fail_now <= 0;
        cmd(tcc_pkg::OP_CSENSE, 0);
        rd(8'h08);
        chk(d, 8);
        cmd(tcc_pkg::OP_RESET, 0);
        rd(8'h04);
        chk(d[0], 0);
        cmd(tcc_pkg::OP_WRITE_EXT, 0);
        chk(tape_en, 0);
        wr(8'h10, 0);
        $display("reject done");
        cmd(tcc_pkg::OP_MODE_SET, 2);
        chk(tape_en, 0);
        cmd(tcc_pkg::OP_MODE_SET, 1);
        rd(8'h04);
        chk(d[2:1], 1);
        cmd(tcc_pkg::OP_WRITE, 0);
        fork
            cmd(tcc_pkg::OP_WRITE, 0);
            begin
                repeat (10) @(posedge aclk);
                rd(8'h04);
                chk(d[25:17], 1);
                stall <= 0;
            end
        join
        $display("modes done");
        {opt_long, aresetn} <= 2'b10;
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        rd(8'h04);
        chk(d[1:0], 2);
        $display("power-on done");
        tally_and_finish;
    end
endmodule : tb_top

//--- tb/tcc_tape_model.sv
// tape engine stand-in: read-ahead source, tape writer, repositioner
// assumes the bench steers offers, stalls and write failures
module tcc_tape_model (
    input  wire logic              aclk,      // clock
    input  wire logic              aresetn,   // sync reset
    input  wire logic              ra_go,     // offer one record
    input  wire tcc_pkg::tcc_rec_t ra_kind,   // status to offer
    input  wire logic              stall,     // hold tape writes
    input  wire logic              fail_now,  // fail cached writes
    input  wire logic              ra_ready,  // record taken
    input  wire logic              wr_avail,  // writes waiting
    input  wire logic              align_req, // reposition asked
    output logic                   ra_valid,  // record offered
    output tcc_pkg::tcc_rec_t      ra_stat,   // record status
    output logic                   wr_done,   // record on tape
    output logic                   wr_fail,   // retries exhausted
    output logic                   align_done // reposition over
);
    // ---------
    // tape side
    // ---------
    always_ff @(posedge aclk) begin
        ra_valid   <= aresetn && (ra_go || (ra_valid && !ra_ready));
        ra_stat    <= ra_go ? ra_kind : (ra_valid ? ra_stat : ~ra_stat);
        // slow tape: one record every other cycle
        wr_done    <= aresetn && wr_avail && !stall && !wr_done;
        wr_fail    <= aresetn && fail_now && wr_avail;
        align_done <= aresetn && align_req && !align_done;
    end
endmodule : tcc_tape_model
